// [tbc_map.svh]
// register offsets, field positions, reset values and timing counts of the timer
`ifndef TBC_MAP_SVH
`define TBC_MAP_SVH
// byte addresses of the register words
`define TBC_ADDR_CTRL       8'h00
`define TBC_ADDR_MODE       8'h04
`define TBC_ADDR_RLD_LO     8'h08
`define TBC_ADDR_RLD_HI     8'h0C
`define TBC_ADDR_CNT_LO     8'h10
`define TBC_ADDR_CNT_HI     8'h14
// control register fields
`define TBC_CTRL_OVF        7
`define TBC_CTRL_EXF        6
`define TBC_CTRL_RXCLK      5
`define TBC_CTRL_TXCLK      4
`define TBC_CTRL_EXEN       3
`define TBC_CTRL_RUN        2
`define TBC_CTRL_CT         1
`define TBC_CTRL_CPRL       0
// mode register fields
`define TBC_MODE_CKOE       1
// reset values
`define TBC_RST_CTRL        8'h00
`define TBC_RST_MODE        8'h00
`define TBC_RST_BYTE        8'h00
// timing: oscillator periods per machine cycle and per state time
`define TBC_OSC_PER_MC      12
`define TBC_OSC_PER_STATE   2
// phase index of the pin sample point and of the count update point
`define TBC_SAMPLE_PHASE    9
`define TBC_UPDATE_PHASE    4
// overflows per serial bit
`define TBC_BAUD_DIV        16
`endif

// [tbc_pkg.sv]
// types shared by the timer files
package tbc_pkg;
    // operating mode decoded from the control bits
    typedef enum logic [1:0] {
        TBC_OFF  = 2'b00,
        TBC_AUTO = 2'b01,
        TBC_CAPT = 2'b10,
        TBC_BAUD = 2'b11
    } tbc_mode_e;
    typedef logic [7:0] tbc_byte_t;
endpackage : tbc_pkg

// [tbc_fall_sampler.sv]
// one sample per machine cycle of a pin, with a one-to-zero detector
`timescale 1ns/1ns
module tbc_fall_sampler (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // pin and sample strobe
    input  wire logic pin_i,
    input  wire logic sample_i,
    // detected falling transition, one clock wide
    output logic      fall_o
);
    logic curr_r;    // last sample taken
    logic fall_r;    // registered detection pulse

    // pin is sampled only at the strobe, so a level shorter than a cycle may be missed
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            curr_r <= 1'b0;
        end else if (sample_i) begin
            curr_r <= pin_i;
        end
    end

    // high in one sample, low in the next: one pulse
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fall_r <= 1'b0;
        end else begin
            fall_r <= sample_i & curr_r & ~pin_i;
        end
    end

    assign fall_o = fall_r;
endmodule : tbc_fall_sampler

// [tbc_timer.sv]
// 16-bit timer/counter with capture, auto-reload, baud and clock-out modes
// Functional notes
// - 16-bit count, timer or counter
// - timer counts each machine cycle
// - count pin read at sample phase
// - count updates at next update phase
// - edge spans two machine cycles
// - mode from run, serial, capture
// - serial select gives baud mode
// - baud rollover reloads from pair
// - baud timer counts per state time
// - bit rate is overflow rate/16
// - baud rollover sets no flag
// - baud trigger sets flag only
// - clock-out: timer select 0, enable 1
// - clock-out toggles per overflow
// - pin: port, count input, clock-out
// - clock-out no flag, shared reload
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "tbc_map.svh"
module tbc_timer #(
    parameter int MC_CLKS   = `TBC_OSC_PER_MC,
    parameter int ST_CLKS   = `TBC_OSC_PER_STATE,
    parameter int SMP_PH    = `TBC_SAMPLE_PHASE,
    parameter int UPD_PH    = `TBC_UPDATE_PHASE,
    parameter int BAUD_DIV  = `TBC_BAUD_DIV
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // shared port pin and its ordinary port function
    input  wire logic        port_pin_i,
    output logic             port_pin_o,
    output logic             port_pin_oe_n_o,
    input  wire logic        gp_data_i,
    input  wire logic        gp_drive_i,
    // external trigger pin
    input  wire logic        trig_pin_i,
    // serial port clocks and status flags
    output logic             tx_bit_tick_o,
    output logic             rx_bit_tick_o,
    output logic             overflow_flag_o,
    output logic             ext_edge_flag_o
);
    // refuse phase figures the sequencer cannot serve
    if (MC_CLKS < 4 || MC_CLKS > 255 || ST_CLKS < 1 || (MC_CLKS % ST_CLKS) != 0 ||
        SMP_PH >= MC_CLKS || UPD_PH >= MC_CLKS || BAUD_DIV < 2 || BAUD_DIV > 256) begin : g_chk
        $error("tbc_timer: unsupported phase or divider parameters");
    end

    localparam logic [7:0] MC_LAST  = 8'(MC_CLKS - 1);
    localparam logic [7:0] ST_LAST  = 8'(ST_CLKS - 1);
    localparam logic [7:0] SMP_AT   = 8'(SMP_PH);
    localparam logic [7:0] UPD_AT   = 8'(UPD_PH);
    localparam logic [7:0] BD_LAST  = 8'(BAUD_DIV - 1);
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // word decode, used by both bus channels
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `TBC_ADDR_CTRL) || (a == `TBC_ADDR_MODE) ||
                    (a == `TBC_ADDR_RLD_LO) || (a == `TBC_ADDR_RLD_HI) ||
                    (a == `TBC_ADDR_CNT_LO) || (a == `TBC_ADDR_CNT_HI);
    endfunction : is_mapped

    // software visible state
    logic [7:0]  timer_control_reg;     // control bits and the two flags
    logic [7:0]  timer_mode_reg;        // clock-out enable
    logic [15:0] reload_r;              // reload/capture pair, high:low
    logic [15:0] count_r;               // count, high:low
    // phase sequencer
    logic [7:0]  phase_r;               // clock within a machine cycle
    logic [7:0]  st_r;                  // clock within a state time
    // internal state
    logic        cnt_pend_r;            // edge seen, waiting for update phase
    logic        clk_out_r;             // clock-out level
    logic        pin_r;                 // registered pin value
    logic        pin_oe_n_r;            // registered pin enable
    logic [7:0]  bdiv_r;                // overflow to bit prescaler
    logic        tx_tick_r;             // transmit bit pulse
    logic        rx_tick_r;             // receive bit pulse
    // bus side state
    logic        aw_got_r;              // write address held
    logic        w_got_r;               // write data held
    logic [7:0]  aw_addr_r;             // held write address
    logic [31:0] w_data_r;              // held write data
    logic        w_lane0_r;             // byte lane 0 enabled
    logic        bvalid_r;              // write response pending
    logic [1:0]  bresp_r;               // write response code
    logic        rvalid_r;              // read response pending
    logic [31:0] rdata_r;               // read data
    logic [1:0]  rresp_r;               // read response code

    // decoded control bits
    logic ct_sel, run, cprl, exen, txclk, rxclk, ckoe;
    assign ct_sel = timer_control_reg[`TBC_CTRL_CT];
    assign run    = timer_control_reg[`TBC_CTRL_RUN];
    assign cprl   = timer_control_reg[`TBC_CTRL_CPRL];
    assign exen   = timer_control_reg[`TBC_CTRL_EXEN];
    assign txclk  = timer_control_reg[`TBC_CTRL_TXCLK];
    assign rxclk  = timer_control_reg[`TBC_CTRL_RXCLK];
    assign ckoe   = timer_mode_reg[`TBC_MODE_CKOE];

    tbc_pkg::tbc_mode_e mode;
    always_comb begin
        if (!run) begin
            mode = tbc_pkg::TBC_OFF;
        end else if (txclk || rxclk) begin
            mode = tbc_pkg::TBC_BAUD;
        end else if (cprl) begin
            mode = tbc_pkg::TBC_CAPT;
        end else begin
            mode = tbc_pkg::TBC_AUTO;
        end
    end

    // clock-out needs timer select low and enable high
    logic clkout_mode;
    assign clkout_mode = ckoe & ~ct_sel;

    // phase sequencer: machine cycles and state times from the clock
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_r <= 8'h00;
            st_r    <= 8'h00;
        end else begin
            phase_r <= (phase_r == MC_LAST) ? 8'h00 : phase_r + 8'h01;
            st_r    <= (st_r == ST_LAST) ? 8'h00 : st_r + 8'h01;
        end
    end

    logic mc_tick, st_tick, smp_tick, upd_tick;
    assign mc_tick  = (phase_r == MC_LAST);
    assign st_tick  = (st_r == ST_LAST);
    assign smp_tick = (phase_r == SMP_AT);
    assign upd_tick = (phase_r == UPD_AT);

    // count pin sampled once per machine cycle
    // shared pin doubles as the count input
    logic cnt_fall, trig_fall;
    tbc_fall_sampler u_cnt_smp (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (port_pin_i),
        .sample_i  (smp_tick),
        .fall_o    (cnt_fall)
    );
    // trigger pin follows the same sample point
    tbc_fall_sampler u_trg_smp (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (trig_pin_i),
        .sample_i  (smp_tick),
        .fall_o    (trig_fall)
    );

    // hold the detected edge until the next update phase
    // so recognition spans two machine cycles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_pend_r <= 1'b0;
        end else if (cnt_fall) begin
            cnt_pend_r <= 1'b1;
        end else if (upd_tick) begin
            cnt_pend_r <= 1'b0;
        end
    end

    // count enable per source; clock-out runs on state times too
    logic fast, inc, ovf, cnt_run;
    assign fast    = ((mode == tbc_pkg::TBC_BAUD) || clkout_mode) && !ct_sel;
    assign cnt_run = run;
    // source chosen by the timer/counter select
    always_comb begin
        if (!cnt_run) begin
            inc = 1'b0;
        end else if (ct_sel) begin
            inc = cnt_pend_r & upd_tick;
        end else if (fast) begin
            inc = st_tick;
        end else begin
            inc = mc_tick;
        end
    end
    assign ovf = inc && (count_r == 16'hFFFF);

    // reload on rollover in every mode except capture with clock-out off
    logic reload_on_ovf;
    assign reload_on_ovf = (mode == tbc_pkg::TBC_BAUD) || clkout_mode ||
                           (mode == tbc_pkg::TBC_AUTO);
    // no overflow flag in baud or clock-out
    logic ovf_flag_set;
    assign ovf_flag_set = ovf && (mode != tbc_pkg::TBC_BAUD) && !clkout_mode;
    // edge flag in every mode while enabled
    logic exf_set;
    assign exf_set = trig_fall & exen;
    // capture only outside baud mode, capture select set
    logic capt;
    assign capt = exf_set && !(txclk || rxclk) && cprl;

    // bus write strobe, taken when both halves are held and no answer pends
    logic wr_go;
    assign wr_go = aw_got_r && w_got_r && !bvalid_r;
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_go && w_lane0_r && (aw_addr_r == a);
    endfunction : wr_hit

    // control register; hardware set wins over a software clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_control_reg <= `TBC_RST_CTRL;
        end else begin
            if (wr_hit(`TBC_ADDR_CTRL)) begin
                timer_control_reg <= w_data_r[7:0];
            end
            if (ovf_flag_set) begin
                timer_control_reg[`TBC_CTRL_OVF] <= 1'b1;
            end
            if (exf_set) begin
                timer_control_reg[`TBC_CTRL_EXF] <= 1'b1;
            end
        end
    end

    // mode register, only the clock-out enable is kept
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_mode_reg <= `TBC_RST_MODE;
        end else if (wr_hit(`TBC_ADDR_MODE)) begin
            timer_mode_reg <= {6'h00, w_data_r[`TBC_MODE_CKOE], 1'b0};
        end
    end

    // reload/capture pair; capture beats a software write
    // writes while running in baud mode may collide with a reload
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reload_r <= {`TBC_RST_BYTE, `TBC_RST_BYTE};
        end else if (capt) begin
            reload_r <= count_r;
        end else begin
            if (wr_hit(`TBC_ADDR_RLD_LO)) begin
                reload_r[7:0] <= w_data_r[7:0];
            end
            if (wr_hit(`TBC_ADDR_RLD_HI)) begin
                reload_r[15:8] <= w_data_r[7:0];
            end
        end
    end

    // count; a software write overrides counting in that cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            count_r <= {`TBC_RST_BYTE, `TBC_RST_BYTE};
        end else begin
            if (ovf && reload_on_ovf) begin
                count_r <= reload_r;
            end else if (inc) begin
                count_r <= count_r + 16'h0001;
            end
            if (wr_hit(`TBC_ADDR_CNT_LO)) begin
                count_r[7:0] <= w_data_r[7:0];
            end
            if (wr_hit(`TBC_ADDR_CNT_HI)) begin
                count_r[15:8] <= w_data_r[7:0];
            end
        end
    end

    // toggle on each overflow gives a square wave at half that rate
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            clk_out_r <= 1'b0;
        end else if (!clkout_mode) begin
            clk_out_r <= 1'b0;
        end else if (ovf) begin
            clk_out_r <= ~clk_out_r;
        end
    end

    // pin carries clock-out when enabled, else the port
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_r      <= 1'b1;
            pin_oe_n_r <= 1'b1;
        end else if (clkout_mode) begin
            pin_r      <= clk_out_r;
            pin_oe_n_r <= 1'b0;
        end else begin
            pin_r      <= gp_data_i;
            pin_oe_n_r <= ~gp_drive_i;
        end
    end

    // one bit pulse per sixteen overflows in baud mode
    logic bd_wrap;
    assign bd_wrap = ovf && (mode == tbc_pkg::TBC_BAUD) && (bdiv_r == BD_LAST);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bdiv_r    <= 8'h00;
            tx_tick_r <= 1'b0;
            rx_tick_r <= 1'b0;
        end else begin
            if (mode != tbc_pkg::TBC_BAUD) begin
                bdiv_r <= 8'h00;
            end else if (ovf) begin
                bdiv_r <= bd_wrap ? 8'h00 : bdiv_r + 8'h01;
            end
            tx_tick_r <= bd_wrap & txclk;
            rx_tick_r <= bd_wrap & rxclk;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_lane0_r <= 1'b0;
        end else if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_got_r) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_got_r) begin
                w_got_r   <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_lane0_r <= s_axi_wstrb[0];
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OK;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= is_mapped(aw_addr_r) ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // read channel; unmapped words read zero with an error
    logic [7:0] ra;
    assign ra = {s_axi_araddr[7:2], 2'b00};
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= RESP_OK;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= is_mapped(ra) ? RESP_OK : RESP_ERR;
            unique case (ra)
                `TBC_ADDR_CTRL:   rdata_r <= {24'h000000, timer_control_reg};
                `TBC_ADDR_MODE:   rdata_r <= {24'h000000, timer_mode_reg};
                `TBC_ADDR_RLD_LO: rdata_r <= {24'h000000, reload_r[7:0]};
                `TBC_ADDR_RLD_HI: rdata_r <= {24'h000000, reload_r[15:8]};
                `TBC_ADDR_CNT_LO: rdata_r <= {24'h000000, count_r[7:0]};
                `TBC_ADDR_CNT_HI: rdata_r <= {24'h000000, count_r[15:8]};
                default:          rdata_r <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // status and serial outputs, all from flip-flops
    assign port_pin_o      = pin_r;
    assign port_pin_oe_n_o = pin_oe_n_r;
    assign tx_bit_tick_o   = tx_tick_r;
    assign rx_bit_tick_o   = rx_tick_r;
    assign overflow_flag_o = timer_control_reg[`TBC_CTRL_OVF];
    assign ext_edge_flag_o = timer_control_reg[`TBC_CTRL_EXF];
endmodule : tbc_timer

// [tbc_timer_properties.sv]
// checker of the timer ports
`timescale 1ns/1ns
module tbc_timer_properties (
    // clock, reset
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // pins, ticks, flags
    input wire logic        port_pin_oe_n_o,
    input wire logic        tx_bit_tick_o,
    input wire logic        overflow_flag_o,
    input wire logic        ext_edge_flag_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read taken beyond the last register word
    sequence rd_unmapped;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] > 6'h05);
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_unmapped_err: assert property (rd_unmapped
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    chk_reset_idle: assert property ($fell(rst_i) |-> port_pin_oe_n_o
        && !overflow_flag_o && !ext_edge_flag_o) else $error("reset state wrong");
    chk_tick_spacing: assert property (tx_bit_tick_o |=> !tx_bit_tick_o [*8])
        else $error("bit tick too close");
endmodule : tbc_timer_properties

bind tbc_timer tbc_timer_properties i_tbc_timer_properties (.*);

// [tbc_pin_model.sv]
// partner model of the count and trigger pins
`timescale 1ns/1ns
module tbc_pin_model (
    // clock, reset, bench controls
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic cnt_en_i,
    input  wire logic trig_go_i,
    // device side of shared pin
    input  wire logic pin_drv_i,
    input  wire logic pin_oe_n_i,
    // resolved pin levels
    output logic      pin_lvl_o,
    output logic      trig_o
);
    logic       src_r;  // count source level
    logic [3:0] ph_r;   // clocks in this level
    logic [4:0] tg_r;   // trigger low time left
    // each level lasts a full machine cycle, the fastest legal rate
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !cnt_en_i) begin
            src_r <= 1'b1;
            ph_r  <= 4'h0;
        end else if (ph_r == 4'hB) begin
            src_r <= ~src_r;
            ph_r  <= 4'h0;
        end else ph_r <= ph_r + 4'h1;
    end
    // trigger low two machine cycles, so any phase sees it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) tg_r <= 5'h00;
        else if (trig_go_i) tg_r <= 5'h18;
        else if (tg_r != 5'h00) tg_r <= tg_r - 5'h01;
    end
    assign trig_o = (tg_r == 5'h00);
    // device drive wins, idle source sits at pull-up level
    assign pin_lvl_o = pin_oe_n_i ? src_r : pin_drv_i;
endmodule : tbc_pin_model

// [tbc_timer_tb_top.sv]
// self-checking bench of the timer
`timescale 1ns/1ns
`include "tbc_map.svh"
module tbc_timer_tb_top;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        gp_data_i = 1'b0, gp_drive_i = 1'b0, cnt_en = 1'b0, trig_go = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        port_pin_i, trig_pin_i, port_pin_o, port_pin_oe_n_o;
    logic        tx_bit_tick_o, rx_bit_tick_o, overflow_flag_o, ext_edge_flag_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    int          fails = 0, total_checks = 0, gap;
    tbc_timer i_tbc_timer (.*);
    tbc_pin_model i_tbc_pin_model (.sys_clk_i, .rst_i, .cnt_en_i(cnt_en),
        .trig_go_i(trig_go), .pin_drv_i(port_pin_o), .pin_oe_n_i(port_pin_oe_n_o),
        .pin_lvl_o(port_pin_i), .trig_o(trig_pin_i));
    // 10 MHz clock
    always #50 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // write: halves offered together; response code kept in rd_r
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ad = 1'b0, wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge sys_clk_i);
            ad = ad | (s_axi_awvalid & s_axi_awready);
            wd = wd | (s_axi_wvalid & s_axi_wready);
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
        rd_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // clocks between two rises: 0 tx tick, 1 pin, 2 rx tick
    task automatic rise_gap(input int s);
        logic p = 1'b1, c;
        int   k = 0;
        while (k < 2) begin
            @(posedge sys_clk_i);
            c = (s == 0) ? tx_bit_tick_o : (s == 1) ? port_pin_o : rx_bit_tick_o;
            gap++;
            if (c === 1'b1 && p === 1'b0) begin
                k++;
                if (k == 1) gap = 0;
            end
            p = c;
        end
    endtask : rise_gap
    task automatic t_regs();
        rd(`TBC_ADDR_CTRL);
        chk("control reset", 32'h0, rd_d);
        rd(`TBC_ADDR_MODE);
        chk("mode reset", 32'h0, rd_d);
        rd(8'h18);
        chk("unmapped resp", 32'h2, {30'h0, rd_r});
        wr(8'h18, 8'h00);
        chk("unmapped write", 32'h2, {30'h0, rd_r});
        gp_drive_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("port drive", 32'h0, {31'h0, port_pin_oe_n_o});
        chk("port level", 32'h0, {31'h0, port_pin_o});
        gp_drive_i <= 1'b0;
    endtask : t_regs
    task automatic load(input logic [7:0] lo);
        wr(`TBC_ADDR_RLD_LO, 8'hFE);
        wr(`TBC_ADDR_RLD_HI, 8'hFF);
        wr(`TBC_ADDR_CNT_LO, lo);
        wr(`TBC_ADDR_CNT_HI, 8'hFF);
    endtask : load
    task automatic t_auto();
        wr(`TBC_ADDR_CNT_LO, 8'h00);
        wr(`TBC_ADDR_CNT_HI, 8'h00);
        wr(`TBC_ADDR_CTRL, 8'h04);
        repeat (120) @(posedge sys_clk_i);
        wr(`TBC_ADDR_CTRL, 8'h00);
        rd(`TBC_ADDR_CNT_LO);
        chk("timer rate", 32'h1, {31'h0, rd_d == 32'hA || rd_d == 32'hB});
        load(8'hFE);
        wr(`TBC_ADDR_CTRL, 8'h04);
        repeat (40) @(posedge sys_clk_i);
        chk("overflow flag", 32'h1, {31'h0, overflow_flag_o});
        wr(`TBC_ADDR_CTRL, 8'h00);
        rd(`TBC_ADDR_CNT_HI);
        chk("reloaded high", 32'hFF, rd_d);
        wr(`TBC_ADDR_CNT_LO, 8'h00);
        wr(`TBC_ADDR_CNT_HI, 8'h00);
        wr(`TBC_ADDR_CTRL, 8'h06);
        cnt_en <= 1'b1;
        repeat (120) @(posedge sys_clk_i);
        cnt_en <= 1'b0;
        repeat (30) @(posedge sys_clk_i);
        wr(`TBC_ADDR_CTRL, 8'h00);
        rd(`TBC_ADDR_CNT_LO);
        chk("event count", 32'h5, rd_d);
    endtask : t_auto
    task automatic t_capt();
        wr(`TBC_ADDR_CNT_LO, 8'h5A);
        wr(`TBC_ADDR_CTRL, 8'h09);
        trig_go <= 1'b1;
        @(posedge sys_clk_i);
        trig_go <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        chk("capture flag", 32'h1, {31'h0, ext_edge_flag_o});
        rd(`TBC_ADDR_RLD_LO);
        chk("captured low", 32'h5A, rd_d);
    endtask : t_capt
    task automatic t_baud();
        load(8'hFE);
        wr(`TBC_ADDR_CTRL, 8'h1C);
        rise_gap(0);
        chk("tx tick gap", 64, gap);
        trig_go <= 1'b1;
        @(posedge sys_clk_i);
        trig_go <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        chk("baud edge flag", 32'h1, {31'h0, ext_edge_flag_o});
        chk("baud overflow", 32'h0, {31'h0, overflow_flag_o});
        wr(`TBC_ADDR_CTRL, 8'h24);
        rise_gap(2);
        chk("rx tick gap", 64, gap);
        wr(`TBC_ADDR_CTRL, 8'h00);
        wr(`TBC_ADDR_MODE, 8'h02);
        wr(`TBC_ADDR_CTRL, 8'h04);
        rise_gap(1);
        chk("clock out period", 8, gap);
        chk("clock out drive", 32'h0, {31'h0, port_pin_oe_n_o});
        chk("clock out overflow", 32'h0, {31'h0, overflow_flag_o});
    endtask : t_baud
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // main sequence after two reset clocks
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_auto();
        t_capt();
        t_baud();
        conclude();
    end
    // watchdog, several times the run
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        conclude();
    end
endmodule : tbc_timer_tb_top
